// ### hw/arsc_pkg.sv
// Constants, field layouts and carrier types of the sector read engine
package arsc_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_FEATURE  = 8'h00;
  localparam logic [7:0] OFS_COUNT    = 8'h04;
  localparam logic [7:0] OFS_SECNUM   = 8'h08;
  localparam logic [7:0] OFS_CYL_LO   = 8'h0c;
  localparam logic [7:0] OFS_CYL_HI   = 8'h10;
  localparam logic [7:0] OFS_DRVHD    = 8'h14;
  localparam logic [7:0] OFS_CMD_STAT = 8'h18;
  localparam logic [7:0] OFS_ERROR    = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // Opcodes
  localparam logic [7:0] OP_READ_RETRY   = 8'h20;
  localparam logic [7:0] OP_READ_NORETRY = 8'h21;

  // Status bit positions
  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DWF  = 5;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_CORR = 2;
  localparam int ST_IDX  = 1;
  localparam int ST_ERR  = 0;

  // Error bit positions
  localparam int ER_BBK  = 7;
  localparam int ER_UNC  = 6;
  localparam int ER_MC   = 5;
  localparam int ER_IDNF = 4;
  localparam int ER_MCR  = 3;
  localparam int ER_ABRT = 2;
  localparam int ER_TK0  = 1;
  localparam int ER_AMNF = 0;

  // Drive/head fields
  localparam int DH_LBA = 6;
  localparam int DH_DRV = 4;

  // Interrupt bits
  localparam int IRQ_W    = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DRQ  = 1;
  localparam int IRQ_ERR  = 2;

  // Reset values and the busy and data request status values
  localparam logic [7:0] TF_RESET   = 8'h00;
  localparam logic [7:0] STAT_IDLE  = 8'h50;
  localparam logic [7:0] STAT_BUSY  = 8'hd0;
  localparam logic [7:0] STAT_DRQ   = 8'h58;
  localparam logic [7:0] ERR_RESET  = 8'h00;

  // Geometry and retry defaults
  localparam int DEF_SPT     = 32;
  localparam int DEF_HEADS   = 16;
  localparam int DEF_RETRIES = 3;

  typedef enum logic [1:0] {MED_OK, MED_CORR, MED_UNC, MED_IDNF} arsc_media_res_type;

  typedef enum logic [1:0] {PH_IDLE, PH_MEDIA, PH_HOST} arsc_phase_type;

  // One sector address; in LBA form head:cyl:sect is LBA[27:0]
  typedef struct packed {
    logic        lba;
    logic [3:0]  head;
    logic [15:0] cyl;
    logic [7:0]  sect;
  } arsc_addr_type;

endpackage

// ### hw/arsc_addr_step.sv
// Next sector address in CHS or LBA form
`timescale 1ns/10ps
module arsc_addr_step #(
  parameter int SPT   = arsc_pkg::DEF_SPT,
  parameter int HEADS = arsc_pkg::DEF_HEADS
) (
  input  arsc_pkg::arsc_addr_type cur,
  output arsc_pkg::arsc_addr_type nxt
);

  localparam logic [7:0] SPT_B  = 8'(SPT);
  localparam logic [3:0] HEAD_L = 4'(HEADS - 1);

  always_comb begin
    nxt = cur;
    if (cur.lba) begin
      {nxt.head, nxt.cyl, nxt.sect} = 28'({cur.head, cur.cyl, cur.sect} + 28'h0000001);
    end else if (cur.sect >= SPT_B) begin
      nxt.sect = 8'h01;
      if (cur.head >= HEAD_L) begin
        nxt.head = 4'h0;
        nxt.cyl  = 16'(cur.cyl + 16'h0001);
      end else begin
        nxt.head = 4'(cur.head + 4'h1);
      end
    end else begin
      nxt.sect = 8'(cur.sect + 8'h01);
    end
  end

endmodule

// ### hw/arsc_irq_ctrl.sv
// Sticky interrupt status, mask and level output
`timescale 1ns/10ps
module arsc_irq_ctrl (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [arsc_pkg::IRQ_W-1:0] ev,
  input  wire logic                       clr_we,
  input  wire logic [arsc_pkg::IRQ_W-1:0] clr_data,
  input  wire logic                       mask_we,
  input  wire logic [arsc_pkg::IRQ_W-1:0] mask_data,
  output logic      [arsc_pkg::IRQ_W-1:0] pend,
  output logic      [arsc_pkg::IRQ_W-1:0] mask,
  output logic                            irq
);

  typedef struct packed {
    logic [arsc_pkg::IRQ_W-1:0] pend;
    logic [arsc_pkg::IRQ_W-1:0] mask;
    logic                       irq;
  } arsc_irq_state_type;

  arsc_irq_state_type s_reg;
  arsc_irq_state_type s_next;

  always_comb begin
    s_next = s_reg;
    // Set wins over a clear in the same cycle
    s_next.pend = (s_reg.pend & ~(clr_we ? clr_data : '0)) | ev;
    if (mask_we) begin
      s_next.mask = mask_data;
    end
    s_next.irq = |(s_next.pend & s_next.mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pend = s_reg.pend;
  assign mask = s_reg.mask;
  assign irq  = s_reg.irq;

endmodule

// ### hw/arsc_top.sv
// Sector read command engine with task file registers on APB
//
// How it works
// - Opcode 20h reads with media retries, 21h reads without retries.
// - Reading starts at the address held in the task file address registers.
// - Consecutive sectors go to the host until the count is delivered.
// - At the end the address registers hold the last good sector, or the start address if no sector was delivered.
// - After an unrecoverable error the count holds sectors not transferred.
// - At the end only uncorrectable and ID-not-found error bits may be set.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
module arsc_top #(
  parameter int SPT     = arsc_pkg::DEF_SPT,
  parameter int HEADS   = arsc_pkg::DEF_HEADS,
  parameter int RETRIES = arsc_pkg::DEF_RETRIES
) (
  input  wire logic                          REF_CLK,
  input  wire logic                          RESET,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [7:0]                    PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  output logic                               MEDIA_REQ,
  output arsc_pkg::arsc_addr_type            MEDIA_ADDR,
  input  wire logic                          MEDIA_DONE,
  input  wire arsc_pkg::arsc_media_res_type  MEDIA_RESULT,
  output logic                               HOST_DRQ,
  input  wire logic                          HOST_SECTOR_DONE,
  output logic                               IRQ
);

  typedef struct packed {
    arsc_pkg::arsc_phase_type phase;
    logic [7:0]               feature;
    logic [7:0]               count;
    logic [7:0]               secnum;
    logic [7:0]               cyl_lo;
    logic [7:0]               cyl_hi;
    logic [7:0]               drvhd;
    logic [7:0]               status;
    logic [7:0]               error;
    arsc_pkg::arsc_addr_type  cur;
    logic [8:0]               remain;
    logic [3:0]               tries;
    logic                     retry_en;
    logic                     corr_seen;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     media_req;
    logic [arsc_pkg::IRQ_W-1:0] ev;
  } arsc_state_type;

  localparam logic [3:0] TRY_MAX = 4'(RETRIES);

  arsc_state_type            s_reg;
  arsc_state_type            s_next;
  arsc_pkg::arsc_addr_type   step_addr;
  arsc_pkg::arsc_addr_type   tf_addr;
  logic [arsc_pkg::IRQ_W-1:0] irq_pend;
  logic [arsc_pkg::IRQ_W-1:0] irq_mask;
  logic                      wr_en;
  logic                      setup;

  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      arsc_pkg::OFS_FEATURE, arsc_pkg::OFS_COUNT, arsc_pkg::OFS_SECNUM,
      arsc_pkg::OFS_CYL_LO, arsc_pkg::OFS_CYL_HI, arsc_pkg::OFS_DRVHD,
      arsc_pkg::OFS_CMD_STAT, arsc_pkg::OFS_ERROR, arsc_pkg::OFS_IRQ_STAT,
      arsc_pkg::OFS_IRQ_MASK: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  // Final status with outcome bits
  function automatic logic [7:0] end_status(input logic corr, input logic err);
    logic [7:0] v;
    v = arsc_pkg::STAT_IDLE;
    v[arsc_pkg::ST_CORR] = corr;
    v[arsc_pkg::ST_ERR]  = err;
    end_status = v;
  endfunction

  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && s_reg.pready && PWRITE && reg_hit(PADDR);

  // Task file viewed as an address
  always_comb begin
    tf_addr      = '0;
    tf_addr.lba  = s_reg.drvhd[arsc_pkg::DH_LBA];
    tf_addr.head = s_reg.drvhd[3:0];
    tf_addr.cyl  = {s_reg.cyl_hi, s_reg.cyl_lo};
    tf_addr.sect = s_reg.secnum;
  end

  arsc_addr_step #(
    .SPT   (SPT),
    .HEADS (HEADS)
  ) u_step (
    .cur (s_reg.cur),
    .nxt (step_addr)
  );

  arsc_irq_ctrl u_irq (
    .clk       (REF_CLK),
    .rst       (RESET),
    .ev        (s_reg.ev),
    .clr_we    (wr_en && PADDR == arsc_pkg::OFS_IRQ_STAT),
    .clr_data  (PWDATA[arsc_pkg::IRQ_W-1:0]),
    .mask_we   (wr_en && PADDR == arsc_pkg::OFS_IRQ_MASK),
    .mask_data (PWDATA[arsc_pkg::IRQ_W-1:0]),
    .pend      (irq_pend),
    .mask      (irq_mask),
    .irq       (IRQ)
  );

  always_comb begin
    s_next           = s_reg;
    s_next.pready    = 1'b0;
    s_next.pslverr   = 1'b0;
    s_next.media_req = 1'b0;
    s_next.ev        = '0;

    // APB read data and answer, registered in the setup cycle
    if (setup) begin
      s_next.pready  = 1'b1;
      s_next.pslverr = !reg_hit(PADDR);
      s_next.prdata  = 32'h00000000;
      case (PADDR)
        arsc_pkg::OFS_COUNT:    s_next.prdata[7:0] = s_reg.count;
        arsc_pkg::OFS_SECNUM:   s_next.prdata[7:0] = s_reg.secnum;
        arsc_pkg::OFS_CYL_LO:   s_next.prdata[7:0] = s_reg.cyl_lo;
        arsc_pkg::OFS_CYL_HI:   s_next.prdata[7:0] = s_reg.cyl_hi;
        arsc_pkg::OFS_DRVHD:    s_next.prdata[7:0] = s_reg.drvhd;
        arsc_pkg::OFS_CMD_STAT: s_next.prdata[7:0] = s_reg.status;
        arsc_pkg::OFS_ERROR:    s_next.prdata[7:0] = s_reg.error;
        arsc_pkg::OFS_IRQ_STAT: s_next.prdata[arsc_pkg::IRQ_W-1:0] = irq_pend;
        arsc_pkg::OFS_IRQ_MASK: s_next.prdata[arsc_pkg::IRQ_W-1:0] = irq_mask;
        default:                s_next.prdata = 32'h00000000;
      endcase
    end

    unique case (s_reg.phase)
      arsc_pkg::PH_IDLE: begin
        // Task file writes only while idle
        if (wr_en) begin
          case (PADDR)
            arsc_pkg::OFS_FEATURE: s_next.feature = PWDATA[7:0];
            arsc_pkg::OFS_COUNT:   s_next.count   = PWDATA[7:0];
            arsc_pkg::OFS_SECNUM:  s_next.secnum  = PWDATA[7:0];
            arsc_pkg::OFS_CYL_LO:  s_next.cyl_lo  = PWDATA[7:0];
            arsc_pkg::OFS_CYL_HI:  s_next.cyl_hi  = PWDATA[7:0];
            arsc_pkg::OFS_DRVHD:   s_next.drvhd   = PWDATA[7:0];
            arsc_pkg::OFS_CMD_STAT: begin
              if (PWDATA[7:0] == arsc_pkg::OP_READ_RETRY ||
                  PWDATA[7:0] == arsc_pkg::OP_READ_NORETRY) begin
                s_next.retry_en  = PWDATA[7:0] == arsc_pkg::OP_READ_RETRY;
                s_next.cur       = tf_addr;
                s_next.remain    = (s_reg.count == 8'h00) ? 9'h100 : {1'b0, s_reg.count};
                s_next.tries     = 4'h0;
                s_next.corr_seen = 1'b0;
                s_next.status    = arsc_pkg::STAT_BUSY;
                s_next.error     = arsc_pkg::ERR_RESET;
                s_next.media_req = 1'b1;
                s_next.phase     = arsc_pkg::PH_MEDIA;
              end else begin
                s_next.status = end_status(1'b0, 1'b1);
                s_next.error  = arsc_pkg::ERR_RESET;
                s_next.error[arsc_pkg::ER_ABRT] = 1'b1;
                s_next.ev[arsc_pkg::IRQ_DONE]   = 1'b1;
                s_next.ev[arsc_pkg::IRQ_ERR]    = 1'b1;
              end
            end
            default: s_next.feature = s_reg.feature;
          endcase
        end
      end
      arsc_pkg::PH_MEDIA: begin
        if (MEDIA_DONE) begin
          unique case (MEDIA_RESULT)
            arsc_pkg::MED_OK, arsc_pkg::MED_CORR: begin
              s_next.corr_seen = s_reg.corr_seen || MEDIA_RESULT == arsc_pkg::MED_CORR;
              s_next.status    = arsc_pkg::STAT_DRQ;
              s_next.status[arsc_pkg::ST_CORR] = s_next.corr_seen;
              s_next.ev[arsc_pkg::IRQ_DRQ]     = 1'b1;
              s_next.phase     = arsc_pkg::PH_HOST;
            end
            arsc_pkg::MED_UNC: begin
              if (s_reg.retry_en && s_reg.tries < TRY_MAX) begin
                s_next.tries     = 4'(s_reg.tries + 4'h1);
                s_next.media_req = 1'b1;
              end else begin
                s_next.count  = s_reg.remain[7:0];
                s_next.error  = arsc_pkg::ERR_RESET;
                s_next.error[arsc_pkg::ER_UNC] = 1'b1;
                s_next.status = end_status(s_reg.corr_seen, 1'b1);
                s_next.ev[arsc_pkg::IRQ_DONE]  = 1'b1;
                s_next.ev[arsc_pkg::IRQ_ERR]   = 1'b1;
                s_next.phase  = arsc_pkg::PH_IDLE;
              end
            end
            arsc_pkg::MED_IDNF: begin
              s_next.count  = s_reg.remain[7:0];
              s_next.error  = arsc_pkg::ERR_RESET;
              s_next.error[arsc_pkg::ER_IDNF] = 1'b1;
              s_next.status = end_status(s_reg.corr_seen, 1'b1);
              s_next.ev[arsc_pkg::IRQ_DONE]   = 1'b1;
              s_next.ev[arsc_pkg::IRQ_ERR]    = 1'b1;
              s_next.phase  = arsc_pkg::PH_IDLE;
            end
          endcase
        end
      end
      arsc_pkg::PH_HOST: begin
        if (HOST_SECTOR_DONE) begin
          // Sector delivered: it becomes the last good address
          s_next.secnum     = s_reg.cur.sect;
          s_next.cyl_lo     = s_reg.cur.cyl[7:0];
          s_next.cyl_hi     = s_reg.cur.cyl[15:8];
          s_next.drvhd[3:0] = s_reg.cur.head;
          s_next.remain     = 9'(s_reg.remain - 9'h001);
          if (s_reg.remain == 9'h001) begin
            s_next.count  = 8'h00;
            s_next.error  = arsc_pkg::ERR_RESET;
            s_next.status = end_status(s_reg.corr_seen, 1'b0);
            s_next.ev[arsc_pkg::IRQ_DONE] = 1'b1;
            s_next.phase  = arsc_pkg::PH_IDLE;
          end else begin
            s_next.cur       = step_addr;
            s_next.tries     = 4'h0;
            s_next.status    = arsc_pkg::STAT_BUSY;
            s_next.media_req = 1'b1;
            s_next.phase     = arsc_pkg::PH_MEDIA;
          end
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      s_reg         <= '0;
      s_reg.phase   <= arsc_pkg::PH_IDLE;
      s_reg.status  <= arsc_pkg::STAT_IDLE;
      s_reg.error   <= arsc_pkg::ERR_RESET;
      s_reg.count   <= arsc_pkg::TF_RESET;
      s_reg.drvhd   <= arsc_pkg::TF_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign PRDATA     = s_reg.prdata;
  assign PREADY     = s_reg.pready;
  assign PSLVERR    = s_reg.pslverr;
  assign MEDIA_REQ  = s_reg.media_req;
  assign MEDIA_ADDR = s_reg.cur;
  assign HOST_DRQ   = s_reg.status[arsc_pkg::ST_DRQ];

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  logic cmd_go;
  logic cmd_end;
  assign cmd_go  = wr_en && PADDR == arsc_pkg::OFS_CMD_STAT && s_reg.phase == arsc_pkg::PH_IDLE
                   && (PWDATA[7:0] == arsc_pkg::OP_READ_RETRY
                       || PWDATA[7:0] == arsc_pkg::OP_READ_NORETRY);
  assign cmd_end = s_reg.phase != arsc_pkg::PH_IDLE && s_next.phase == arsc_pkg::PH_IDLE;

  sequence apb_setup_s;
    PSEL && !PENABLE;
  endsequence

  sequence sector_taken_s;
    s_reg.phase == arsc_pkg::PH_HOST && HOST_SECTOR_DONE;
  endsequence

  apb_answer_a: assert property (apb_setup_s |=> PREADY)
    else $error("APB answer missing");
  opcode_start_a: assert property (cmd_go
                                   |=> MEDIA_REQ && s_reg.phase == arsc_pkg::PH_MEDIA
                                   && s_reg.status[arsc_pkg::ST_BSY])
    else $error("Read opcode did not start");
  start_addr_a: assert property (cmd_go |=> MEDIA_ADDR == $past(tf_addr))
    else $error("Wrong start address");
  count_load_a: assert property (cmd_go && s_reg.count != 8'h00
                                 |=> s_reg.remain == {1'b0, $past(s_reg.count)})
    else $error("Sector count not loaded");
  next_sector_a: assert property (sector_taken_s ##0 s_reg.remain > 9'h001
                                  |=> MEDIA_REQ ##0 MEDIA_ADDR == $past(step_addr))
    else $error("Next sector not requested");
  last_good_a: assert property (sector_taken_s
                                |=> s_reg.secnum == $past(s_reg.cur.sect)
                                && s_reg.drvhd[3:0] == $past(s_reg.cur.head))
    else $error("Last good address not kept");
  untransferred_a: assert property (cmd_end && s_reg.phase == arsc_pkg::PH_MEDIA
                                    |=> s_reg.count == $past(s_reg.remain[7:0]))
    else $error("Remaining count wrong");
  error_bits_a: assert property (cmd_end |=> (s_reg.error & 8'haf) == 8'h00)
    else $error("Forbidden error bit set");
  end_status_a: assert property (cmd_end
                                 |=> s_reg.status[7:4] == 4'h5
                                 && !s_reg.status[arsc_pkg::ST_IDX]
                                 && s_reg.status[arsc_pkg::ST_ERR] == (s_reg.error != 8'h00))
    else $error("End status wrong");

endmodule

// ### test/arsc_media_model.sv
// Media side model answering sector read requests
`timescale 1ns/10ps
module arsc_media_model (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         req,
  input  wire arsc_pkg::arsc_addr_type      addr,
  input  wire logic                         slow,
  output logic                              done,
  output arsc_pkg::arsc_media_res_type      result
);
  arsc_pkg::arsc_addr_type      bad_addr;
  arsc_pkg::arsc_media_res_type bad_kind;
  int                           fails_left;
  int                           wait_cnt;
  logic                         hit;

  initial begin
    bad_addr = '0;
    bad_kind = arsc_pkg::MED_OK;
    fails_left = 0;
    wait_cnt = 0;
    hit = 1'b0;
    done = 1'b0;
    result = arsc_pkg::MED_OK;
  end

  // Reply after one or six cycles; result scrambled outside replies
  always @(posedge clk) begin
    done <= 1'b0;
    result <= arsc_pkg::arsc_media_res_type'(~result);
    if (rst) begin
      wait_cnt <= 0;
    end else if (req) begin
      wait_cnt <= slow ? 6 : 1;
      hit <= (addr == bad_addr) && (fails_left > 0);
    end else if (wait_cnt == 1) begin
      wait_cnt <= 0;
      done <= 1'b1;
      result <= hit ? bad_kind : arsc_pkg::MED_OK;
      if (hit) fails_left <= fails_left - 1;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// ### test/tb_ata_read_sectors_cmd.sv
// Self-checking bench of the sector read engine
`timescale 1ns/10ps
module tb_ata_read_sectors_cmd;
  logic                         ref_clk;
  logic                         reset;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [7:0]                   paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         media_req;
  arsc_pkg::arsc_addr_type      media_addr;
  logic                         media_done;
  arsc_pkg::arsc_media_res_type media_result;
  logic                         host_drq;
  logic                         host_done;
  logic                         irq;
  logic                         slow;
  logic [31:0]                  rd_val;
  logic                         er_val;
  int                           err_total;
  int                           checks_done;
  int                           cycles;
  int                           got;
  arsc_pkg::arsc_addr_type      exp_q[$];

  arsc_top #(.SPT(32), .HEADS(16), .RETRIES(3)) dut (
    .REF_CLK(ref_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MEDIA_REQ(media_req), .MEDIA_ADDR(media_addr), .MEDIA_DONE(media_done),
    .MEDIA_RESULT(media_result), .HOST_DRQ(host_drq), .HOST_SECTOR_DONE(host_done),
    .IRQ(irq)
  );

  arsc_media_model media (
    .clk(ref_clk), .rst(reset), .req(media_req), .addr(media_addr), .slow(slow),
    .done(media_done), .result(media_result)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd_val = prdata;
    er_val = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, {24'h0, exp}, rd_val);
    chk("slverr", 0, {31'h0, er_val});
  endtask

  task load(input logic [7:0] dh, hi, lo, sn, cnt);
    wr(arsc_pkg::OFS_DRVHD, dh);
    wr(arsc_pkg::OFS_CYL_HI, hi);
    wr(arsc_pkg::OFS_CYL_LO, lo);
    wr(arsc_pkg::OFS_SECNUM, sn);
    wr(arsc_pkg::OFS_COUNT, cnt);
  endtask

  task run_cmd(input logic [7:0] op);
    got = 0;
    wr(arsc_pkg::OFS_CMD_STAT, op);
    do begin
      apb(1'b0, arsc_pkg::OFS_CMD_STAT, 32'h0);
      if (rd_val[arsc_pkg::ST_DRQ] === 1'b1) begin
        chk("drq pin", 1, {31'h0, host_drq});
        @(posedge ref_clk);
        host_done <= 1'b1;
        @(posedge ref_clk);
        host_done <= 1'b0;
        got++;
      end
    end while (rd_val[7] !== 1'b0 || rd_val[3] !== 1'b0);
    chk("drq pin idle", 0, {31'h0, host_drq});
    chk("pending media requests", 0, exp_q.size());
  endtask

  task chk_end(input logic [7:0] st, er, cnt, sn, lo, hi, input logic [3:0] hd);
    rd_chk("status", arsc_pkg::OFS_CMD_STAT, st);
    rd_chk("error", arsc_pkg::OFS_ERROR, er);
    rd_chk("count", arsc_pkg::OFS_COUNT, cnt);
    rd_chk("sector", arsc_pkg::OFS_SECNUM, sn);
    rd_chk("cyl low", arsc_pkg::OFS_CYL_LO, lo);
    rd_chk("cyl high", arsc_pkg::OFS_CYL_HI, hi);
    apb(1'b0, arsc_pkg::OFS_DRVHD, 32'h0);
    chk("head nibble", {28'h0, hd}, {28'h0, rd_val[3:0]});
  endtask

  task t_reset;
    rd_chk("status", arsc_pkg::OFS_CMD_STAT, arsc_pkg::STAT_IDLE);
    rd_chk("error", arsc_pkg::OFS_ERROR, arsc_pkg::ERR_RESET);
    rd_chk("feature", arsc_pkg::OFS_FEATURE, 8'h00);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped slverr", 1, {31'h0, er_val});
    $display("test reset done");
  endtask

  task t_lba;
    wr(arsc_pkg::OFS_IRQ_MASK, 8'h07);
    load(8'h41, 8'h23, 8'h45, 8'hfe, 8'h03);
    media.bad_addr = {1'b1, 4'h1, 16'h2345, 8'hff};
    media.bad_kind = arsc_pkg::MED_CORR;
    media.fails_left = 1;
    exp_q.push_back({1'b1, 4'h1, 16'h2345, 8'hfe});
    exp_q.push_back({1'b1, 4'h1, 16'h2345, 8'hff});
    exp_q.push_back({1'b1, 4'h1, 16'h2346, 8'h00});
    run_cmd(arsc_pkg::OP_READ_RETRY);
    chk("sectors", 3, got);
    chk_end(8'h54, 8'h00, 8'h00, 8'h00, 8'h46, 8'h23, 4'h1);
    chk("irq", 1, {31'h0, irq});
    rd_chk("irq pending", arsc_pkg::OFS_IRQ_STAT, 8'h03);
    wr(arsc_pkg::OFS_IRQ_STAT, 8'h07);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", 0, {31'h0, irq});
    $display("test lba done");
  endtask

  task t_chs_unc;
    slow <= 1'b1;
    wr(arsc_pkg::OFS_IRQ_MASK, 8'h00);
    load(8'h00, 8'h00, 8'h05, 8'h20, 8'h03);
    media.bad_addr = {1'b0, 4'h1, 16'h0005, 8'h01};
    media.bad_kind = arsc_pkg::MED_UNC;
    media.fails_left = 1;
    exp_q.push_back({1'b0, 4'h0, 16'h0005, 8'h20});
    exp_q.push_back({1'b0, 4'h1, 16'h0005, 8'h01});
    run_cmd(arsc_pkg::OP_READ_NORETRY);
    chk("sectors", 1, got);
    chk_end(8'h51, 8'h40, 8'h02, 8'h20, 8'h05, 8'h00, 4'h0);
    chk("irq masked", 0, {31'h0, irq});
    apb(1'b0, arsc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("error pending", 1, {31'h0, rd_val[arsc_pkg::IRQ_ERR]});
    wr(arsc_pkg::OFS_IRQ_STAT, 8'h07);
    $display("test chs error done");
  endtask

  task t_retry_idnf;
    slow <= 1'b0;
    load(8'h40, 8'h00, 8'h00, 8'h10, 8'h01);
    media.bad_addr = {1'b1, 4'h0, 16'h0000, 8'h10};
    media.bad_kind = arsc_pkg::MED_UNC;
    media.fails_left = 2;
    repeat (3) exp_q.push_back({1'b1, 4'h0, 16'h0000, 8'h10});
    run_cmd(arsc_pkg::OP_READ_RETRY);
    chk("sectors", 1, got);
    chk_end(arsc_pkg::STAT_IDLE, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 4'h0);
    load(8'h40, 8'h00, 8'h00, 8'h20, 8'h02);
    media.bad_addr = {1'b1, 4'h0, 16'h0000, 8'h20};
    media.bad_kind = arsc_pkg::MED_IDNF;
    media.fails_left = 3;
    exp_q.push_back({1'b1, 4'h0, 16'h0000, 8'h20});
    run_cmd(arsc_pkg::OP_READ_RETRY);
    chk("sectors", 0, got);
    chk_end(8'h51, 8'h10, 8'h02, 8'h20, 8'h00, 8'h00, 4'h0);
    run_cmd(8'h30);
    rd_chk("abort error", arsc_pkg::OFS_ERROR, 8'h04);
    wr(arsc_pkg::OFS_IRQ_STAT, 8'h07);
    $display("test retry and id done");
  endtask

  always @(posedge ref_clk) begin
    if (media_req === 1'b1) begin
      if (exp_q.size() == 0) chk("extra media request", 0, 1);
      else chk("media address", exp_q.pop_front(), media_addr);
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    cycles = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    host_done = 1'b0;
    slow = 1'b0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_lba();
    t_chs_unc();
    t_retry_idnf();
    report_and_stop();
  end
endmodule
